/* File: cfg_host.sv */
// Host model for the serial register port: header byte, one data byte.
// Assumes the bench clock; SCLK phases of 5 clocks, mode 0, MSB first.
`timescale 1ns/10ps
module cfg_host (
    input  wire logic i_clk,
    input  wire logic i_miso,
    output logic      o_csn,
    output logic      o_sclk,
    output logic      o_mosi
);
    initial begin
        o_csn  = 1'b1;
        o_sclk = 1'b0;
        o_mosi = 1'b0;
    end
    // IF retune lives outside this bank
    task automatic wait_clk(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask
    // MISO taken just before each rise, while it is settled
    task automatic shift(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            o_mosi = tx[i];
            wait_clk(5);
            rx[i]  = i_miso;
            o_sclk = 1'b1;
            wait_clk(5);
            o_sclk = 1'b0;
        end
    endtask
    task automatic xfer(input logic [7:0] hdr, input logic [7:0] wd,
                        output logic [7:0] rd);
        logic [7:0] st;
        o_csn = 1'b0;
        shift(hdr, st);
        shift(wd, rd);
        wait_clk(8);
        o_csn  = 1'b1;
        // Released line is driven with the last bit inverted; never leave the last bit showing
        o_mosi = ~o_mosi;
        wait_clk(4);
    endtask
endmodule // cfg_host

/* File: modem_cfg_pkg.sv */
// Constants for the modem configuration register bank.
// Assumes an 8-bit serial register port with a 6-bit address.
package modem_cfg_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register offsets
    localparam logic [5:0] OFS_BANDWIDTH_RATE_EXP = 6'h10;
    localparam logic [5:0] OFS_RATE_MANTISSA      = 6'h11;
    localparam logic [5:0] OFS_FILTER_MODULATION  = 6'h12;

    ////////////////////////////////////////////////////////////////////////
    // Field positions (low bit of each field)
    localparam int POS_BANDWIDTH_EXPONENT   = 6;
    localparam int POS_BANDWIDTH_MANTISSA   = 4;
    localparam int POS_SYMBOL_RATE_EXPONENT = 0;
    localparam int POS_SYMBOL_RATE_MANTISSA = 0;
    localparam int POS_DC_FILTER_BYPASS     = 7;
    localparam int POS_MODULATION_CODE      = 4;

    ////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [1:0] RST_BANDWIDTH_EXPONENT   = 2'h2;
    localparam logic [1:0] RST_BANDWIDTH_MANTISSA   = 2'h0;
    localparam logic [3:0] RST_SYMBOL_RATE_EXPONENT = 4'hC;
    localparam logic [7:0] RST_SYMBOL_RATE_MANTISSA = 8'h22;
    localparam logic       RST_DC_FILTER_BYPASS     = 1'b0;
    localparam logic [2:0] RST_MODULATION_CODE      = 3'h0;

    ////////////////////////////////////////////////////////////////////////
    // Modulation codes
    localparam logic [2:0] MOD_2FSK = 3'h0;
    localparam logic [2:0] MOD_GFSK = 3'h1;
    localparam logic [2:0] MOD_ASK  = 3'h3;
    localparam logic [2:0] MOD_MSK  = 3'h7;

    ////////////////////////////////////////////////////////////////////////
    // Rate arithmetic
    localparam int          BW_FIXED_DIV    = 8;
    localparam logic [2:0]  BW_MANTISSA_ADD = 3'h4;
    localparam logic [8:0]  SR_HIDDEN_ONE   = 9'h100;
    localparam int          SR_FRAC_BITS    = 28;

    ////////////////////////////////////////////////////////////////////////
    // Serial port header layout
    localparam int HDR_READ_BIT  = 7;
    localparam int HDR_BURST_BIT = 6;
    localparam logic [7:0] HDR_STATUS = 8'h00;

endpackage

/* File: modem_cfg_sva.sv */
// Checker for the modem configuration bank, top-level ports only.
// Assumes one clock domain; bound at the foot of this file.
`timescale 1ns/10ps
module modem_cfg_sva #(
    parameter int ACC_W = 28
) (
    input wire logic       i_clk,
    input wire logic       i_rst,
    input wire logic       i_ce,
    input wire logic       i_csn,
    input wire logic [1:0] o_bandwidth_exponent,
    input wire logic [1:0] o_bandwidth_mantissa,
    input wire logic [8:0] o_decimation_ratio,
    input wire logic [3:0] o_symbol_rate_exponent,
    input wire logic [7:0] o_symbol_rate_mantissa,
    input wire logic       o_symbol_tick,
    input wire logic       o_dc_filter_bypass,
    input wire logic [2:0] o_modulation_code,
    input wire logic       o_mod_2fsk,
    input wire logic       o_mod_gfsk,
    input wire logic       o_mod_ask,
    input wire logic       o_mod_msk,
    input wire logic       o_mod_unassigned
);
    localparam longint PER = longint'(1) << ACC_W;
    logic [19:0] fields;
    logic [23:0] incr;
    logic [23:0] incr_ff;
    logic [31:0] gap_ff;
    logic [31:0] nxt_gap;
    logic [1:0]  ticks_ff;
    logic [1:0]  nxt_ticks;
    assign fields = {o_bandwidth_exponent, o_bandwidth_mantissa,
                     o_symbol_rate_exponent, o_symbol_rate_mantissa,
                     o_dc_filter_bypass, o_modulation_code};
    assign incr = 24'(9'h100 + o_symbol_rate_mantissa)
                  << o_symbol_rate_exponent;
    ////////////////////////////////////////////////////////////////////////
    // Gap since last tick; early gaps after a change may mix increments
    always_comb begin
        nxt_gap   = o_symbol_tick ? 32'h1 : gap_ff + 32'h1;
        nxt_ticks = ticks_ff;
        if (incr != incr_ff || !i_ce) begin
            nxt_ticks = 2'h0;
        end else if (o_symbol_tick && ticks_ff != 2'h3) begin
            nxt_ticks = ticks_ff + 2'h1;
        end
    end
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            gap_ff   <= 32'h0;
            ticks_ff <= 2'h0;
            incr_ff  <= 24'h0;
        end else begin
            gap_ff   <= nxt_gap;
            ticks_ff <= nxt_ticks;
            incr_ff  <= incr;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    sequence run_edge;
        $past(i_ce) && !$past(i_rst);
    endsequence
    sequence csn_idle;
        i_csn [*8];
    endsequence
    reset_vals_a: assert property ($past(i_rst) && $past(i_ce) |->
        fields == 20'h8C220) else $error("fields not at reset values");
    dec_ratio_a: assert property (run_edge |-> o_decimation_ratio ==
        (9'(4 + $past(o_bandwidth_mantissa)) << 3)
        << $past(o_bandwidth_exponent)) else $error("bad decimation");
    mod_fsk_a: assert property (run_edge |->
        o_mod_2fsk == ($past(o_modulation_code) == 3'h0) &&
        o_mod_gfsk == ($past(o_modulation_code) == 3'h1))
        else $error("fsk decode wrong");
    mod_ask_a: assert property (run_edge |->
        o_mod_ask == ($past(o_modulation_code) == 3'h3) &&
        o_mod_msk == ($past(o_modulation_code) == 3'h7))
        else $error("ask or msk decode wrong");
    mod_none_a: assert property (run_edge |-> o_mod_unassigned ==
        ($past(o_modulation_code) inside {3'h2, 3'h4, 3'h5, 3'h6}))
        else $error("unassigned decode wrong");
    fields_hold_a: assert property (csn_idle |-> $stable(fields))
        else $error("field moved while deselected");
    // A frozen clock enable holds the pulse, so only running edges count
    tick_single_a: assert property (o_symbol_tick && i_ce |=>
        !o_symbol_tick)
        else $error("tick wider than one cycle");
    tick_gap_a: assert property (o_symbol_tick && ticks_ff >= 2'h2 |->
        longint'(gap_ff) * incr > PER - incr &&
        longint'(gap_ff) * incr < PER + incr) else $error("tick gap wrong");
endmodule // modem_cfg_sva

bind modem_config_registers modem_cfg_sva #(.ACC_W(ACC_W)) sva (
    .i_clk, .i_rst, .i_ce, .i_csn, .o_bandwidth_exponent,
    .o_bandwidth_mantissa, .o_decimation_ratio, .o_symbol_rate_exponent,
    .o_symbol_rate_mantissa, .o_symbol_tick, .o_dc_filter_bypass,
    .o_modulation_code, .o_mod_2fsk, .o_mod_gfsk, .o_mod_ask, .o_mod_msk,
    .o_mod_unassigned
);

/* File: modem_config_registers.sv */
// Modem configuration register bank with bandwidth and symbol rate logic.
// Assumes i_clk is the crystal clock; host reaches it over the serial port.
`timescale 1ns/10ps

// Notes on behaviour
// - Decimation ratio is 8 times (4 plus mantissa) times two to exponent.
// - Bandwidth exponent bits 7:6 reset 2; mantissa bits 5:4 reset 0.
// - Symbol rate mantissa has a hidden ninth one bit; exponent four bits.
// - Symbol rate is (256 plus mantissa) times 2^exp over 2^28 times clock.
// - Symbol rate exponent sits in bits 3:0 of first register, reset 12.
// - Symbol rate mantissa fills second register, resetting to 0x22.
// - Bit 7 of third register bypasses the DC blocking filter; reset 0.
// - Bits 6:4 pick modulation: 000 2-FSK, 001 GFSK, 011 ASK/OOK.
module modem_config_registers #(
    parameter int ACC_W = modem_cfg_pkg::SR_FRAC_BITS
) (
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire logic       i_ce,
    input  wire logic       i_csn,
    input  wire logic       i_sclk,
    input  wire logic       i_mosi,
    output logic            o_miso,
    output logic [1:0]      o_bandwidth_exponent,
    output logic [1:0]      o_bandwidth_mantissa,
    output logic [8:0]      o_decimation_ratio,
    output logic [3:0]      o_symbol_rate_exponent,
    output logic [7:0]      o_symbol_rate_mantissa,
    output logic            o_symbol_tick,
    output logic            o_dc_filter_bypass,
    output logic [2:0]      o_modulation_code,
    output logic            o_mod_2fsk,
    output logic            o_mod_gfsk,
    output logic            o_mod_ask,
    output logic            o_mod_msk,
    output logic            o_mod_unassigned
);

    // Increment stays just under 2^24, so the accumulator must hold more than 24 bits
    if (ACC_W < 25 || ACC_W > 40) begin : g_bad_acc_w
        $error("ACC_W must lie in 25..40");
    end

    ////////////////////////////////////////////////////////////////////////
    // Serial register port
    logic [5:0] rd_addr;
    logic [7:0] rd_data;
    logic       wr_en;
    logic [5:0] wr_addr;
    logic [7:0] wr_data;

    serial_reg_port u_port (
        .i_clk     (i_clk),
        .i_rst     (i_rst),
        .i_ce      (i_ce),
        .i_csn     (i_csn),
        .i_sclk    (i_sclk),
        .i_mosi    (i_mosi),
        .i_rdata   (rd_data),
        .o_miso    (o_miso),
        .o_addr    (rd_addr),
        .o_wr_en   (wr_en),
        .o_wr_addr (wr_addr),
        .o_wdata   (wr_data)
    );

    ////////////////////////////////////////////////////////////////////////
    // Field storage
    logic [1:0] bw_exp_ff,  nxt_bw_exp;
    logic [1:0] bw_man_ff,  nxt_bw_man;
    logic [3:0] sr_exp_ff,  nxt_sr_exp;
    logic [7:0] sr_man_ff,  nxt_sr_man;
    logic       dc_byp_ff,  nxt_dc_byp;
    logic [2:0] mod_ff,     nxt_mod;

    always_comb begin
        nxt_bw_exp = bw_exp_ff;
        nxt_bw_man = bw_man_ff;
        nxt_sr_exp = sr_exp_ff;
        nxt_sr_man = sr_man_ff;
        nxt_dc_byp = dc_byp_ff;
        nxt_mod    = mod_ff;
        if (wr_en) begin
            case (wr_addr)
                modem_cfg_pkg::OFS_BANDWIDTH_RATE_EXP: begin
                    nxt_bw_exp = wr_data[modem_cfg_pkg::POS_BANDWIDTH_EXPONENT
                                         +: 2];
                    nxt_bw_man = wr_data[modem_cfg_pkg::POS_BANDWIDTH_MANTISSA
                                         +: 2];
                    nxt_sr_exp = wr_data[
                        modem_cfg_pkg::POS_SYMBOL_RATE_EXPONENT +: 4];
                end
                modem_cfg_pkg::OFS_RATE_MANTISSA: begin
                    nxt_sr_man = wr_data[
                        modem_cfg_pkg::POS_SYMBOL_RATE_MANTISSA +: 8];
                end
                modem_cfg_pkg::OFS_FILTER_MODULATION: begin
                    nxt_dc_byp = wr_data[modem_cfg_pkg::POS_DC_FILTER_BYPASS];
                    nxt_mod    = wr_data[modem_cfg_pkg::POS_MODULATION_CODE
                                         +: 3];
                end
                // Unmapped writes are dropped
                default: nxt_mod = mod_ff;
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            bw_exp_ff <= modem_cfg_pkg::RST_BANDWIDTH_EXPONENT;
            bw_man_ff <= modem_cfg_pkg::RST_BANDWIDTH_MANTISSA;
            sr_exp_ff <= modem_cfg_pkg::RST_SYMBOL_RATE_EXPONENT;
            sr_man_ff <= modem_cfg_pkg::RST_SYMBOL_RATE_MANTISSA;
            dc_byp_ff <= modem_cfg_pkg::RST_DC_FILTER_BYPASS;
            mod_ff    <= modem_cfg_pkg::RST_MODULATION_CODE;
        end else if (i_ce) begin
            bw_exp_ff <= nxt_bw_exp;
            bw_man_ff <= nxt_bw_man;
            sr_exp_ff <= nxt_sr_exp;
            sr_man_ff <= nxt_sr_man;
            dc_byp_ff <= nxt_dc_byp;
            mod_ff    <= nxt_mod;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read-back; unused bits and unmapped offsets read zero
    always_comb begin
        rd_data = 8'h00;
        case (rd_addr)
            modem_cfg_pkg::OFS_BANDWIDTH_RATE_EXP: begin
                rd_data[modem_cfg_pkg::POS_BANDWIDTH_EXPONENT +: 2] =
                    bw_exp_ff;
                rd_data[modem_cfg_pkg::POS_BANDWIDTH_MANTISSA +: 2] =
                    bw_man_ff;
                rd_data[modem_cfg_pkg::POS_SYMBOL_RATE_EXPONENT +: 4] =
                    sr_exp_ff;
            end
            modem_cfg_pkg::OFS_RATE_MANTISSA: begin
                rd_data[modem_cfg_pkg::POS_SYMBOL_RATE_MANTISSA +: 8] =
                    sr_man_ff;
            end
            modem_cfg_pkg::OFS_FILTER_MODULATION: begin
                rd_data[modem_cfg_pkg::POS_DC_FILTER_BYPASS] = dc_byp_ff;
                rd_data[modem_cfg_pkg::POS_MODULATION_CODE +: 3] =
                    mod_ff;
            end
            default: rd_data = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Derived settings: decimation, symbol timing, modulation decode
    logic [8:0]       dec_ff,  nxt_dec;
    logic [ACC_W-1:0] acc_ff,  nxt_acc;
    logic             tick_ff, nxt_tick;
    logic [4:0]       modd_ff, nxt_modd;

    always_comb begin
        logic [8:0]     base;
        logic [23:0]    incr;
        logic [ACC_W:0] sum;
        // 8 * (4 + M) fits in 6 bits; exponent shifts by up to 3
        base    = 9'({modem_cfg_pkg::BW_MANTISSA_ADD + {1'b0, bw_man_ff}, 3'h0})
                  ;
        nxt_dec = base << bw_exp_ff;
        // Hidden one above the stored mantissa
        incr    = 24'(modem_cfg_pkg::SR_HIDDEN_ONE
                      | {1'b0, sr_man_ff}) << sr_exp_ff;
        // Phase accumulator: carry out of 2^28 is one symbol period
        sum      = {1'b0, acc_ff} + (ACC_W + 1)'(incr);
        nxt_acc  = sum[ACC_W-1:0];
        nxt_tick = sum[ACC_W];
        nxt_modd = 5'h00;
        case (mod_ff)
            modem_cfg_pkg::MOD_2FSK: nxt_modd = 5'h01;
            modem_cfg_pkg::MOD_GFSK: nxt_modd = 5'h02;
            modem_cfg_pkg::MOD_ASK:  nxt_modd = 5'h04;
            modem_cfg_pkg::MOD_MSK:  nxt_modd = 5'h08;
            default:                 nxt_modd = 5'h10;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            dec_ff  <= 9'h000;
            acc_ff  <= '0;
            tick_ff <= 1'b0;
            modd_ff <= 5'h01;
        end else if (i_ce) begin
            dec_ff  <= nxt_dec;
            acc_ff  <= nxt_acc;
            tick_ff <= nxt_tick;
            modd_ff <= nxt_modd;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign o_bandwidth_exponent   = bw_exp_ff;
    assign o_bandwidth_mantissa   = bw_man_ff;
    assign o_decimation_ratio     = dec_ff;
    assign o_symbol_rate_exponent = sr_exp_ff;
    assign o_symbol_rate_mantissa = sr_man_ff;
    assign o_symbol_tick          = tick_ff;
    // Bypass saves current; sensitivity drops, so keep below 250 kBaud
    assign o_dc_filter_bypass     = dc_byp_ff;
    assign o_modulation_code      = mod_ff;
    assign o_mod_2fsk             = modd_ff[0];
    assign o_mod_gfsk             = modd_ff[1];
    assign o_mod_ask              = modd_ff[2];
    assign o_mod_msk              = modd_ff[3];
    assign o_mod_unassigned       = modd_ff[4];

endmodule // modem_config_registers

/* File: modem_config_registers_test.sv */
// Bench for the modem configuration bank through its serial port.
// Assumes cfg_host as the host; ACC_W cut to 25 for faster ticks.
`timescale 1ns/10ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin \
    miscompares++; $display("[FAIL] %0t got %0h exp %0h", $time, g, e); \
    end end
module modem_config_registers_test;
    logic       i_clk, i_rst, i_ce, i_csn, i_sclk, i_mosi, o_miso;
    logic [1:0] o_bandwidth_exponent, o_bandwidth_mantissa;
    logic [8:0] o_decimation_ratio;
    logic [3:0] o_symbol_rate_exponent;
    logic [7:0] o_symbol_rate_mantissa;
    logic       o_symbol_tick, o_dc_filter_bypass;
    logic [2:0] o_modulation_code;
    logic       o_mod_2fsk, o_mod_gfsk, o_mod_ask, o_mod_msk;
    logic       o_mod_unassigned;
    logic [7:0] model [3];
    logic [7:0] rd;
    int         miscompares, cmp_count, cycles, n;
    modem_config_registers #(.ACC_W(25)) dut (.i_clk, .i_rst, .i_ce,
        .i_csn, .i_sclk, .i_mosi, .o_miso, .o_bandwidth_exponent,
        .o_bandwidth_mantissa, .o_decimation_ratio, .o_symbol_rate_exponent,
        .o_symbol_rate_mantissa, .o_symbol_tick, .o_dc_filter_bypass,
        .o_modulation_code, .o_mod_2fsk, .o_mod_gfsk, .o_mod_ask,
        .o_mod_msk, .o_mod_unassigned);
    cfg_host host (.i_clk, .i_miso(o_miso), .o_csn(i_csn),
                   .o_sclk(i_sclk), .o_mosi(i_mosi));
    initial begin
        i_clk = 1'b0;
        forever #50 i_clk = ~i_clk;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        logic [7:0] r;
        host.xfer({2'b00, a}, d, r);
        if (a inside {6'h10, 6'h11, 6'h12}) begin
            model[a[1:0]] = (a == 6'h12) ? (d & 8'hF0) : d;
        end
    endtask
    task automatic check_all();
        logic [2:0] m;
        logic [8:0] dr;
        for (int i = 0; i < 3; i++) begin
            host.xfer({2'b10, 6'h10 + 6'(i)}, 8'h00, rd);
            `CHK(rd, model[i])
        end
        m  = model[2][6:4];
        dr = 9'((4 + model[0][5:4]) * 8) << model[0][7:6];
        `CHK(o_bandwidth_exponent, model[0][7:6])
        `CHK(o_bandwidth_mantissa, model[0][5:4])
        `CHK(o_decimation_ratio, dr)
        `CHK(o_symbol_rate_exponent, model[0][3:0])
        `CHK(o_symbol_rate_mantissa, model[1])
        `CHK(o_dc_filter_bypass, model[2][7])
        `CHK(o_modulation_code, m)
        `CHK(o_mod_2fsk, m == 3'h0)
        `CHK(o_mod_gfsk, m == 3'h1)
        `CHK(o_mod_ask, m == 3'h3)
        `CHK(o_mod_msk, m == 3'h7)
        `CHK(o_mod_unassigned, m inside {3'h2, 3'h4, 3'h5, 3'h6})
    endtask
    task automatic summarize();
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // About 10200 cycles expected
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            summarize();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        i_rst = 1'b1;
        i_ce  = 1'b1;
        model = '{8'h8C, 8'h22, 8'h00};
        repeat (5) @(posedge i_clk);
        #1 i_rst = 1'b0;
        host.wait_clk(4);
        check_all();
        $display("test reset_values done");
        wr(6'h10, 8'hFF);
        check_all();
        wr(6'h10, 8'h30);
        check_all();
        wr(6'h11, 8'h55);
        check_all();
        $display("test field_writes done");
        // Slow rate first, so the bypass is legal
        wr(6'h10, 8'h8C);
        wr(6'h11, 8'h22);
        for (int c = 0; c < 8; c++) begin
            wr(6'h12, {c[0], 3'(c), 4'hF});
            check_all();
        end
        $display("test modulation_codes done");
        wr(6'h13, 8'hFF);
        check_all();
        host.xfer(8'h93, 8'h00, rd);
        `CHK(rd, 8'h00)
        $display("test unmapped done");
        wr(6'h10, 8'h0F);
        wr(6'h11, 8'h00);
        n = 0;
        repeat (40) begin
            @(posedge i_clk);
            #1;
            if (o_symbol_tick === 1'b1) n++;
        end
        `CHK(n, 10)
        $display("test symbol_tick done");
        // Enable low must freeze the accumulator and its pulse
        i_ce = 1'b0;
        rd   = {7'h00, o_symbol_tick};
        n    = 0;
        repeat (20) begin
            @(posedge i_clk);
            #1;
            if (o_symbol_tick !== rd[0]) n++;
        end
        i_ce = 1'b1;
        `CHK(n, 0)
        $display("test clock_enable done");
        i_rst = 1'b1;
        host.wait_clk(2);
        i_rst = 1'b0;
        model = '{8'h8C, 8'h22, 8'h00};
        host.wait_clk(4);
        check_all();
        $display("test second_reset done");
        summarize();
    end
endmodule // modem_config_registers_test

/* File: serial_reg_port.sv */
// Serial register port: mode 0, MSB first, header byte then data bytes.
// Assumes SCLK well below a quarter of i_clk; pins are asynchronous.
`timescale 1ns/10ps
module serial_reg_port (
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire logic       i_ce,
    input  wire logic       i_csn,
    input  wire logic       i_sclk,
    input  wire logic       i_mosi,
    input  wire logic [7:0] i_rdata,
    output logic            o_miso,
    output logic [5:0]      o_addr,
    output logic            o_wr_en,
    output logic [5:0]      o_wr_addr,
    output logic [7:0]      o_wdata
);

    typedef enum logic {PH_HEADER, PH_DATA} phase_e;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; second stage is the only reader of the first
    logic [2:0] sync1_ff;
    logic [2:0] sync2_ff;
    logic       sclk_d_ff;

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            // Idle pin levels: CSn high, SCLK low, so no false edge
            sync1_ff  <= 3'h4;
            sync2_ff  <= 3'h4;
            sclk_d_ff <= 1'b0;
        end else if (i_ce) begin
            sync1_ff  <= {i_csn, i_sclk, i_mosi};
            sync2_ff  <= sync1_ff;
            sclk_d_ff <= sync2_ff[1];
        end
    end

    logic csn_s;
    logic mosi_s;
    logic rise;
    logic fall;
    assign csn_s  = sync2_ff[2];
    assign mosi_s = sync2_ff[0];
    assign rise   = sync2_ff[1] & ~sclk_d_ff;
    assign fall   = ~sync2_ff[1] & sclk_d_ff;

    ////////////////////////////////////////////////////////////////////////
    // Shift engine
    phase_e     phase_ff,  nxt_phase;
    logic [2:0] bit_ff,    nxt_bit;
    logic [7:0] rx_ff,     nxt_rx;
    logic [7:0] tx_ff,     nxt_tx;
    logic [5:0] addr_ff,   nxt_addr;
    logic       read_ff,   nxt_read;
    logic       burst_ff,  nxt_burst;
    logic       done_ff,   nxt_done;
    logic       wr_ff,     nxt_wr;
    logic [5:0] waddr_ff,  nxt_waddr;
    logic [7:0] wdata_ff,  nxt_wdata;

    always_comb begin
        logic [7:0] byte_in;
        byte_in   = {rx_ff[6:0], mosi_s};
        nxt_phase = phase_ff;
        nxt_bit   = bit_ff;
        nxt_rx    = rx_ff;
        nxt_tx    = tx_ff;
        nxt_addr  = addr_ff;
        nxt_read  = read_ff;
        nxt_burst = burst_ff;
        nxt_done  = done_ff;
        nxt_wr    = 1'b0;
        nxt_waddr = waddr_ff;
        nxt_wdata = wdata_ff;
        if (csn_s) begin
            nxt_phase = PH_HEADER;
            nxt_bit   = 3'h0;
            nxt_done  = 1'b0;
            nxt_tx    = modem_cfg_pkg::HDR_STATUS;
        end else if (rise) begin
            nxt_rx  = byte_in;
            nxt_bit = bit_ff + 3'h1;
            if (bit_ff == 3'h7) begin
                nxt_done = 1'b1;
                case (phase_ff)
                    PH_HEADER: begin
                        nxt_addr  = byte_in[5:0];
                        nxt_read  = byte_in[modem_cfg_pkg::HDR_READ_BIT];
                        nxt_burst = byte_in[modem_cfg_pkg::HDR_BURST_BIT];
                        nxt_phase = PH_DATA;
                    end
                    PH_DATA: begin
                        nxt_wr    = ~read_ff;
                        nxt_waddr = addr_ff;
                        nxt_wdata = byte_in;
                        // Burst walks the map; single access repeats
                        if (burst_ff) begin
                            nxt_addr = addr_ff + 6'h01;
                        end
                    end
                    default: nxt_phase = PH_HEADER;
                endcase
            end
        end else if (fall) begin
            // Load at the byte edge so the MSB is ready for the next rise
            if (done_ff) begin
                nxt_tx   = read_ff ? i_rdata : 8'h00;
                nxt_done = 1'b0;
            end else begin
                nxt_tx = {tx_ff[6:0], 1'b0};
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            phase_ff <= PH_HEADER;
            bit_ff   <= 3'h0;
            rx_ff    <= 8'h00;
            tx_ff    <= 8'h00;
            addr_ff  <= 6'h00;
            read_ff  <= 1'b0;
            burst_ff <= 1'b0;
            done_ff  <= 1'b0;
            wr_ff    <= 1'b0;
            waddr_ff <= 6'h00;
            wdata_ff <= 8'h00;
        end else if (i_ce) begin
            phase_ff <= nxt_phase;
            bit_ff   <= nxt_bit;
            rx_ff    <= nxt_rx;
            tx_ff    <= nxt_tx;
            addr_ff  <= nxt_addr;
            read_ff  <= nxt_read;
            burst_ff <= nxt_burst;
            done_ff  <= nxt_done;
            wr_ff    <= nxt_wr;
            waddr_ff <= nxt_waddr;
            wdata_ff <= nxt_wdata;
        end
    end

    assign o_miso    = tx_ff[7];
    assign o_addr    = addr_ff;
    assign o_wr_en   = wr_ff;
    assign o_wr_addr = waddr_ff;
    assign o_wdata   = wdata_ff;

endmodule // serial_reg_port
